/* rtl/ahi_host_port.sv */
`timescale 1ns/10ps
`include "ahi_params.svh"
// Notes on behaviour
// - Hardware mode: pair pins pick pair 0..7
// - Leaving any reset: pins give initial pair
// - Pins sampled while busy pick next pair
// - Software mode: channel register, default pair 0
// - Start edge begins conversion; busy until ready
// - Parallel bus driven only when select, read low
// - Select rise floats bus, select fall releases
// - First read after busy gives A, next B
// - Writing zero to address zero exits register mode
// - Write word: bit15 one, address, nine data
// - Parallel write latched on write-strobe rise
// - Read command loads register into output word
// - Returned word carries register address
// - Two-line: A on out a; one-line: A then B
// - One-wire select fixed at full reset release
// - Select fall shows MSB; clock rise shifts next
// - One-line results need 32 clocks, one or two frames
// - Serial read returns data in following frame
// - Register mode returns previously addressed register
// - Hardware mode refuses all register access
// - Range pins zero at full reset: software mode
module ahi_host_port (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_partial_resetn,
    input  wire ahi_pkg::ahi_pair_t  i_pair_select_pins,
    input  wire ahi_pkg::ahi_range_t i_range_mode_pins,
    input  wire logic             i_serial_parallel_select,
    input  wire logic             i_one_wire_select,
    input  wire logic             i_convert_start,
    input  wire logic             i_cs_n,
    input  wire logic             i_rd_n,
    input  wire logic             i_wr_n,
    input  wire logic             i_sclk,
    input  wire logic             i_serial_command_in,
    input  wire ahi_pkg::ahi_word_t  i_parallel_data_bus,
    output ahi_pkg::ahi_word_t       o_parallel_data_bus,
    output logic                  o_parallel_data_bus_oe_n,
    output logic                  o_serial_out_a,
    output logic                  o_serial_out_a_oe_n,
    output logic                  o_serial_out_b,
    output logic                  o_serial_out_b_oe_n,
    output logic                  o_busy,
    output logic                  o_conv_start,
    output ahi_pkg::ahi_pair_t       o_conv_pair,
    input  wire logic             i_conv_done,
    input  wire ahi_pkg::ahi_word_t  i_result_a,
    input  wire ahi_pkg::ahi_word_t  i_result_b,
    output logic                  o_reg_wr,
    output ahi_pkg::ahi_addr_t       o_reg_addr,
    output ahi_pkg::ahi_data_t       o_reg_wdata,
    input  wire ahi_pkg::ahi_data_t  i_reg_rdata,
    output logic                  o_software_mode,
    output logic                  o_register_mode
);
    import ahi_pkg::*;

    // ******************************************
    // Pin synchronisation
    // ******************************************
    localparam int SW = 30;             // Synchronised pin count

    logic [SW-1:0] pin_raw;             // Outside pins except i_resetn
    logic [SW-1:0] pin_q;               // Settled levels
    logic [SW-1:0] pin_rise;            // Rising edges
    logic [SW-1:0] pin_fall;            // Falling edges

    assign pin_raw = {i_parallel_data_bus, i_pair_select_pins,
                      i_range_mode_pins, i_serial_parallel_select,
                      i_one_wire_select, i_convert_start, i_cs_n,
                      i_rd_n, i_wr_n, i_sclk, i_serial_command_in,
                      i_partial_resetn};

    // Data bus goes through the same two stages as the
    // strobes, so a write edge sees data of the same age
    ahi_sync #(.W(SW)) u_sync (
        .i_clk  (i_clk),
        .i_d    (pin_raw),
        .o_q    (pin_q),
        .o_rise (pin_rise),
        .o_fall (pin_fall)
    );

    // Named views of the settled pins
    ahi_word_t  db_in;                  // Parallel input word
    ahi_pair_t  pair_pins;              // Pair select level
    ahi_range_t range_pins;             // Range mode level
    logic       ser_pin;                // Serial select level
    logic       one_pin;                // One-wire select level
    logic       start_rise;             // Conversion start edge
    logic       cs_low;                 // Chip select asserted
    logic       cs_fall;                // Select falling edge
    logic       rd_low;                 // Read strobe asserted
    logic       rd_fall;                // Read strobe falling edge
    logic       wr_rise;                // Write strobe rising edge
    logic       sclk_rise;              // Serial clock rise
    logic       sclk_fall;              // Serial clock fall
    logic       serial_command_in;                    // Serial command bit
    logic       part_low;               // Partial reset held
    logic       part_rise;              // Partial reset release

    assign db_in      = pin_q[29:14];
    assign pair_pins  = pin_q[13:11];
    assign range_pins = pin_q[10:9];
    assign ser_pin    = pin_q[8];
    assign one_pin    = pin_q[7];
    assign start_rise = pin_rise[6];
    assign cs_low     = ~pin_q[5];
    assign cs_fall    = pin_fall[5];
    assign rd_low     = ~pin_q[4];
    assign rd_fall    = pin_fall[4];
    assign wr_rise    = pin_rise[3];
    assign sclk_rise  = pin_rise[2];
    assign sclk_fall  = pin_fall[2];
    assign serial_command_in        = pin_q[1];
    assign part_low   = ~pin_q[0];
    assign part_rise  = pin_rise[0];

    // ******************************************
    // Configuration latched at full reset release
    // ******************************************
    logic cfg_done;                     // Strap capture finished
    logic sw_mode;                      // Software mode
    logic ser_mode;                     // Serial interface
    logic two_line;                     // Two data-out lines

    // Straps caught on the first clock after release,
    // since an asynchronous capture could latch a glitch
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cfg_done <= 1'b0;
            sw_mode  <= 1'b0;
            ser_mode <= 1'b0;
            two_line <= 1'b0;
        end else if (!cfg_done) begin
            cfg_done <= 1'b1;
            sw_mode  <= (range_pins == `AHI_SW_MODE_CODE);
            ser_mode <= ser_pin;
            two_line <= one_pin;
        end
    end

    assign o_software_mode = sw_mode;

    // ******************************************
    // Conversion control and pair selection
    // ******************************************
    logic      busy;                    // Conversion in flight
    ahi_pair_t hw_pair;                 // Pin-chosen pair
    ahi_pair_t sw_pair;                 // Channel register pair
    ahi_word_t res_a;                   // Held A result
    ahi_word_t res_b;                   // Held B result
    logic      conv_go;                 // Start accepted
    logic      part_rel;                // Partial reset released

    assign conv_go = start_rise & ~busy & cfg_done & ~part_low;

    // Pins stay unlatched: reloaded on any reset exit and
    // tracked while busy so the next start uses them
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            hw_pair  <= `AHI_PAIR_DEFAULT;
            part_rel <= 1'b0;
        end else begin
            part_rel <= part_rise;
            if (!cfg_done || part_rel) begin
                hw_pair <= pair_pins;
            end else if (busy) begin
                hw_pair <= pair_pins;
            end
        end
    end

    // Busy from accepted start until the core is done
    always_ff @(posedge i_clk) begin
        if (!i_resetn || part_low) begin
            busy         <= 1'b0;
            o_conv_start <= 1'b0;
            o_conv_pair  <= `AHI_PAIR_DEFAULT;
        end else begin
            o_conv_start <= conv_go;
            if (conv_go) begin
                busy        <= 1'b1;
                o_conv_pair <= sw_mode ? sw_pair : hw_pair;
            end else if (i_conv_done) begin
                busy <= 1'b0;
            end
        end
    end

    // Results captured as busy falls
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            res_a <= `AHI_WORD_ZERO;
            res_b <= `AHI_WORD_ZERO;
        end else if (busy && i_conv_done) begin
            res_a <= i_result_a;
            res_b <= i_result_b;
        end
    end

    assign o_busy = busy;

    // ******************************************
    // Command decode shared by both interfaces
    // ******************************************
    ahi_word_t ser_in;                  // Serial command shifter
    logic [3:0] bit_cnt;                // Bits taken this word
    ahi_word_t cmd;                     // Word being executed
    logic      par_cmd;                 // Parallel command strobe
    logic      ser_cmd;                 // Serial command strobe
    logic      cmd_take;                // Command accepted
    logic      cmd_wr;                  // Write command
    ahi_addr_t cmd_addr;                // Command address
    ahi_data_t cmd_data;                // Command payload
    logic      cmd_exit;                // Register mode exit
    logic      reg_mode;                // Readback of registers
    logic      rb_load;                 // Parallel readback pending

    assign par_cmd  = ~ser_mode & cs_low & wr_rise;
    assign ser_cmd  = ser_mode & cs_low & sclk_fall
                      & (bit_cnt == `AHI_LAST_BIT);
    assign cmd      = ser_mode ? {ser_in[14:0], serial_command_in} : db_in;
    assign cmd_take = sw_mode & (par_cmd | ser_cmd);
    assign cmd_wr   = cmd[`AHI_CMD_WR_BIT];
    assign cmd_addr = cmd[`AHI_CMD_ADDR_HI:`AHI_CMD_ADDR_LO];
    assign cmd_data = cmd[`AHI_CMD_DATA_HI:0];
    assign cmd_exit = cmd_wr & (cmd_addr == `AHI_EXIT_ADDR)
                      & (cmd_data == `AHI_EXIT_DATA);

    // Register side effects of an accepted command
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            reg_mode    <= 1'b0;
            o_reg_wr    <= 1'b0;
            o_reg_addr  <= `AHI_EXIT_ADDR;
            o_reg_wdata <= `AHI_EXIT_DATA;
            sw_pair     <= `AHI_PAIR_DEFAULT;
            rb_load     <= 1'b0;
        end else begin
            o_reg_wr <= cmd_take & cmd_wr;
            rb_load  <= cmd_take & ~cmd_wr & ~ser_mode;
            if (cmd_take) begin
                o_reg_addr <= cmd_addr;
                reg_mode   <= ~cmd_exit;
                if (cmd_wr) begin
                    o_reg_wdata <= cmd_data;
                end
                if (cmd_wr && cmd_addr == `AHI_CHAN_ADDR) begin
                    sw_pair <= cmd_data[`AHI_CHAN_PAIR_HI:0];
                end
            end
        end
    end

    assign o_register_mode = reg_mode;

    // Readback word with the address echoed in its middle
    ahi_word_t rb_word;
    assign rb_word = {1'b0, o_reg_addr, i_reg_rdata};

    // ******************************************
    // Parallel interface
    // ******************************************
    logic rd_b_next;                    // Next read gives B

    // Word chosen by read strobes or by a read command
    always_ff @(posedge i_clk) begin
        if (!i_resetn || part_low) begin
            o_parallel_data_bus <= `AHI_WORD_ZERO;
            rd_b_next           <= 1'b0;
        end else if (busy && i_conv_done) begin
            rd_b_next <= 1'b0;
        end else if (rb_load) begin
            o_parallel_data_bus <= rb_word;
        end else if (!ser_mode && cs_low && rd_fall) begin
            if (reg_mode) begin
                o_parallel_data_bus <= rb_word;
            end else begin
                o_parallel_data_bus <= rd_b_next ? res_b : res_a;
                rd_b_next           <= ~rd_b_next;
            end
        end
    end

    // Driven only inside select and read; select edges
    // float and release it directly
    assign o_parallel_data_bus_oe_n = ser_mode | ~cs_low | ~rd_low;

    // ******************************************
    // Serial interface
    // ******************************************
    logic [31:0] sh_a;                  // Out-a shift chain
    ahi_word_t   sh_b;                  // Out-b shift word
    logic        ser_b_next;            // One-line frame owes B
    logic [3:0]  out_cnt;               // Bits shifted out
    logic        half_done;             // First word of 32 sent

    // Frame load at select fall, shift on clock rise
    always_ff @(posedge i_clk) begin
        if (!i_resetn || part_low) begin
            sh_a       <= {`AHI_WORD_ZERO, `AHI_WORD_ZERO};
            sh_b       <= `AHI_WORD_ZERO;
            ser_b_next <= 1'b0;
            out_cnt    <= `AHI_BIT_ZERO;
            half_done  <= 1'b0;
        end else if (busy && i_conv_done) begin
            ser_b_next <= 1'b0;
        end else if (ser_mode && cs_fall) begin
            out_cnt   <= `AHI_BIT_ZERO;
            half_done <= 1'b0;
            if (reg_mode) begin
                sh_a <= {rb_word, `AHI_WORD_ZERO};
                sh_b <= `AHI_WORD_ZERO;
            end else if (!two_line && ser_b_next) begin
                sh_a       <= {res_b, `AHI_WORD_ZERO};
                ser_b_next <= 1'b0;
            end else begin
                sh_a <= {res_a, res_b};
                sh_b <= res_b;
            end
        end else if (ser_mode && cs_low && sclk_rise) begin
            sh_a    <= {sh_a[30:0], 1'b0};
            sh_b    <= {sh_b[14:0], 1'b0};
            out_cnt <= out_cnt + 4'h1;
            if (out_cnt == `AHI_LAST_BIT && !half_done) begin
                half_done  <= 1'b1;
                // Select lifted now leaves B for a new frame
                ser_b_next <= ~two_line & ~reg_mode;
            end else if (out_cnt == `AHI_LAST_BIT) begin
                ser_b_next <= 1'b0;
            end
        end
    end

    // Command bits taken on the clock fall
    always_ff @(posedge i_clk) begin
        if (!i_resetn || part_low) begin
            ser_in  <= `AHI_WORD_ZERO;
            bit_cnt <= `AHI_BIT_ZERO;
        end else if (ser_mode && cs_fall) begin
            bit_cnt <= `AHI_BIT_ZERO;
        end else if (ser_mode && cs_low && sclk_fall) begin
            ser_in  <= {ser_in[14:0], serial_command_in};
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // Output stages register the chain heads
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_serial_out_a <= 1'b0;
            o_serial_out_b <= 1'b0;
        end else begin
            o_serial_out_a <= sh_a[31];
            o_serial_out_b <= sh_b[15];
        end
    end

    // Out-b floats in one-line mode
    assign o_serial_out_a_oe_n = ~ser_mode | ~cs_low;
    assign o_serial_out_b_oe_n = ~ser_mode | ~cs_low | ~two_line;
endmodule

/* rtl/ahi_params.svh */
`ifndef AHI_PARAMS_SVH
`define AHI_PARAMS_SVH
// Command word layout
`define AHI_CMD_WR_BIT   15
`define AHI_CMD_ADDR_HI  14
`define AHI_CMD_ADDR_LO  9
`define AHI_CMD_DATA_HI  8
// Register-mode exit command
`define AHI_EXIT_ADDR    6'h00
`define AHI_EXIT_DATA    9'h000
// Channel register address and its pair field
`define AHI_CHAN_ADDR    6'h03
`define AHI_CHAN_PAIR_HI 2
// Reset values
`define AHI_PAIR_DEFAULT 3'h0
`define AHI_WORD_ZERO    16'h0000
`define AHI_SW_MODE_CODE 2'h0
// Serial framing
`define AHI_LAST_BIT     4'hf
`define AHI_BIT_ZERO     4'h0
`endif

/* rtl/ahi_pkg.sv */
package ahi_pkg;
    typedef logic [15:0] ahi_word_t;  // Data bus / command word
    typedef logic [5:0]  ahi_addr_t;  // Register index
    typedef logic [8:0]  ahi_data_t;  // Register payload
    typedef logic [2:0]  ahi_pair_t;  // Channel pair index
    typedef logic [1:0]  ahi_range_t; // Range mode pins
endpackage

/* rtl/ahi_sync.sv */
`timescale 1ns/10ps
// ******************************************
// Two-flop synchroniser with edge detection
// ******************************************
module ahi_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    logic [W-1:0] meta;   // First stage, read only by o_q
    logic [W-1:0] q_d;    // Delayed copy for edges

    // Data stages carry no reset so that pin levels are
    // already valid when the reset is released
    always_ff @(posedge i_clk) begin
        meta <= i_d;
        o_q  <= meta;
        q_d  <= o_q;
    end

    // Edge detection on the settled stage only
    assign o_rise = o_q & ~q_d;
    assign o_fall = ~o_q & q_d;
endmodule

/* tb/ahi_core_model.sv */
`timescale 1ns/10ps
// ********************************
// Converter core and register file
// ********************************
module ahi_core_model #(
    parameter int DELAY = 20 // Conversion length in clocks
) (
    input  wire logic               i_clk,
    input  wire logic               i_resetn,
    input  wire logic               i_conv_start,
    input  wire ahi_pkg::ahi_pair_t i_conv_pair,
    input  wire logic               i_reg_wr,
    input  wire ahi_pkg::ahi_addr_t i_reg_addr,
    input  wire ahi_pkg::ahi_data_t i_reg_wdata,
    output logic                    o_conv_done,
    output ahi_pkg::ahi_word_t      o_result_a,
    output ahi_pkg::ahi_word_t      o_result_b,
    output ahi_pkg::ahi_data_t      o_reg_rdata
);
    import ahi_pkg::*;
    ahi_data_t regs [64]; // Register contents
    int        cnt;       // Cycles left in conversion
    assign o_reg_rdata = regs[i_reg_addr];
    // Results tag the pair so a wrong pair shows in the data
    always_ff @(posedge i_clk) begin
        o_conv_done <= (cnt == 1);
        if (!i_resetn) begin
            cnt <= 0;
            o_result_a <= '0;
            o_result_b <= '0;
            foreach (regs[k]) regs[k] <= '0;
        end else if (i_conv_start) begin
            cnt <= DELAY;
            o_result_a <= 16'ha000 | 16'(i_conv_pair);
            o_result_b <= 16'hb000 | 16'(i_conv_pair);
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
        if (i_resetn && i_reg_wr) begin
            regs[i_reg_addr] <= i_reg_wdata;
        end
    end
endmodule

/* tb/ahi_host_port_properties.sv */
`timescale 1ns/10ps
// ********************************
// Port checker for the host port
// ********************************
module ahi_host_port_checker (
    input wire logic               i_clk,
    input wire logic               i_resetn,
    input wire logic               i_partial_resetn,
    input wire logic               i_cs_n,
    input wire logic               i_rd_n,
    input wire logic               i_convert_start,
    input wire logic               i_conv_done,
    input wire ahi_pkg::ahi_pair_t i_pair_select_pins,
    input wire logic               o_parallel_data_bus_oe_n,
    input wire logic               o_busy,
    input wire logic               o_conv_start,
    input wire ahi_pkg::ahi_pair_t o_conv_pair,
    input wire logic               o_reg_wr,
    input wire ahi_pkg::ahi_addr_t o_reg_addr,
    input wire ahi_pkg::ahi_data_t o_reg_wdata,
    input wire logic               o_software_mode,
    input wire logic               o_register_mode
);
    import ahi_pkg::*;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    // Six cycles covers the strobe synchroniser delay
    AST_CS_FLOAT: assert property (i_cs_n [*6] |->
        o_parallel_data_bus_oe_n) else $error("bus driven, cs high");
    AST_RD_FLOAT: assert property (i_rd_n [*6] |->
        o_parallel_data_bus_oe_n) else $error("bus driven, rd high");
    AST_START_BUSY: assert property (
        $rose(i_convert_start) && !o_busy |-> ##[1:6] o_busy)
        else $error("start edge gave no busy");
    AST_START_PULSE: assert property (
        o_conv_start |-> ##[0:1] o_busy) else $error("start w/o busy");
    AST_BUSY_FALL: assert property (
        i_conv_done && o_busy |=> !o_busy) else $error("busy stuck");
    AST_BUSY_STANDS: assert property (
        $fell(o_busy) |-> $past(i_conv_done))
        else $error("busy fell early");
    // Pins as held through the last reset or busy period
    ahi_pair_t held_pins;
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !i_partial_resetn || o_busy) begin
            held_pins <= i_pair_select_pins;
        end
    end
    // The next start must use the pair those pins chose
    AST_HW_PAIR: assert property (
        o_conv_start && !o_software_mode |->
        o_conv_pair == held_pins) else $error("wrong pair");
    AST_HW_NO_REG: assert property (
        !o_software_mode |-> !o_reg_wr && !o_register_mode)
        else $error("register access in hardware mode");
    AST_EXIT_REG: assert property (
        o_reg_wr && o_reg_addr == 6'h00 && o_reg_wdata == 9'h000
        |-> ##[0:2] !o_register_mode) else $error("no mode exit");
    // Straps land on the first edge after release, then freeze
    AST_MODE_FIXED: assert property (
        $past(i_resetn) && $past(i_resetn, 2) |->
        $stable(o_software_mode)) else $error("mode changed");
    COV_CONV: cover property ($fell(o_busy));
    COV_REG_WR: cover property (o_reg_wr);
    COV_EXIT: cover property ($fell(o_register_mode));
endmodule

bind ahi_host_port ahi_host_port_checker ahi_host_port_checker_i (.*);

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
    import ahi_pkg::*;
    // ****************************
    // Pins and counters
    // ****************************
    logic i_clk = 0, i_resetn = 0, i_partial_resetn = 1;
    logic i_serial_parallel_select = 0, i_one_wire_select = 1;
    logic i_convert_start = 0, i_cs_n = 1, i_rd_n = 1, i_wr_n = 1;
    logic i_sclk = 0, i_serial_command_in = 0;
    ahi_pair_t  i_pair_select_pins = '0;
    ahi_range_t i_range_mode_pins = '0;
    ahi_word_t  i_parallel_data_bus = '0, o_parallel_data_bus;
    logic o_parallel_data_bus_oe_n, o_serial_out_a, o_serial_out_b;
    logic o_serial_out_a_oe_n, o_serial_out_b_oe_n, o_busy;
    logic o_conv_start, i_conv_done, o_reg_wr;
    logic o_software_mode, o_register_mode;
    ahi_pair_t  o_conv_pair;
    ahi_word_t  i_result_a, i_result_b, qa, qb;
    ahi_addr_t  o_reg_addr;
    ahi_data_t  o_reg_wdata, i_reg_rdata;
    ahi_pair_t  e;
    logic       tl; // Two-line strap as booted
    int         bad_count = 0, n_tests = 0;
    always #2 i_clk = ~i_clk; // 250 MHz
    ahi_host_port ahi_host_port_i (.*);
    ahi_core_model ahi_core_model_i (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_conv_start(o_conv_start),
        .i_conv_pair(o_conv_pair), .i_reg_wr(o_reg_wr),
        .i_reg_addr(o_reg_addr), .i_reg_wdata(o_reg_wdata),
        .o_conv_done(i_conv_done), .o_result_a(i_result_a),
        .o_result_b(i_result_b), .o_reg_rdata(i_reg_rdata));
    // ****************************
    // Access tasks
    // ****************************
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic chk(input ahi_word_t got, input ahi_word_t exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait on busy; a hang counts as a mismatch
    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (o_busy !== v && k < 300) begin
            step(1);
            k++;
        end
        chk(o_busy, v);
    endtask
    // Pins for the next pair settle before the start edge
    // and hold until busy falls
    task automatic conv(input ahi_pair_t p);
        i_pair_select_pins <= p;
        step(1);
        i_convert_start <= 1;
        step(4);
        i_convert_start <= 0;
        wait_busy(1);
        wait_busy(0);
        step(4);
    endtask
    task automatic pwr(input ahi_word_t w);
        i_cs_n <= 0;
        i_parallel_data_bus <= w;
        i_wr_n <= 0;
        step(6);
        i_wr_n <= 1;
        step(6);
        i_cs_n <= 1;
        i_parallel_data_bus <= ~w; // Stale bus data is not kept
        step(6);
    endtask
    task automatic prd(input ahi_word_t exp);
        i_cs_n <= 0;
        i_rd_n <= 0;
        step(8);
        chk(o_parallel_data_bus, exp);
        chk(o_parallel_data_bus_oe_n, 0);
        i_rd_n <= 1;
        i_cs_n <= 1;
        step(8);
        chk(o_parallel_data_bus_oe_n, 1);
    endtask
    // One 16-clock frame; sclk idles low, 160 ns period
    task automatic sfr(input ahi_word_t cmd, output ahi_word_t a, b);
        i_cs_n <= 0;
        step(8);
        chk(o_serial_out_a_oe_n, 0);
        chk(o_serial_out_b_oe_n, !tl);
        for (int i = 15; i >= 0; i--) begin
            step(20);
            a[i] = o_serial_out_a;
            b[i] = o_serial_out_b;
            // Command bit moves with the rise, taken at the fall
            i_serial_command_in <= cmd[i];
            i_sclk <= 1;
            step(20);
            i_sclk <= 0;
        end
        step(20);
        i_cs_n <= 1;
        i_serial_command_in <= ~i_serial_command_in;
        step(8);
        chk(o_serial_out_a_oe_n, 1);
    endtask
    task automatic boot(input ahi_range_t r, input logic sp, ow,
                        input ahi_pair_t p);
        i_resetn <= 0;
        i_range_mode_pins <= r;
        i_serial_parallel_select <= sp;
        i_one_wire_select <= ow;
        tl = ow;
        i_pair_select_pins <= p;
        step(8);
        i_resetn <= 1;
        step(8);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****************************
    // Tests
    // ****************************
    initial begin
        // Hardware mode, parallel: every pair code
        boot(2'h1, 1'b0, 1'b1, 3'h5);
        e = 3'h5;
        for (int p = 0; p < 9; p++) begin
            conv(3'(p));
            prd(16'ha000 | 16'(e));
            prd(16'hb000 | 16'(e));
            e = 3'(p);
        end
        pwr(16'h8605);
        chk(o_register_mode, 0);
        conv(3'h0);
        prd(16'ha000);
        prd(16'hb000);
        // Partial reset reloads the pair from the pins
        i_pair_select_pins <= 3'h3;
        i_partial_resetn <= 0;
        step(8);
        i_partial_resetn <= 1;
        step(8);
        conv(3'h3);
        prd(16'ha003);
        prd(16'hb003);
        $display("test hw_parallel done");
        // Software mode, parallel register access
        boot(2'h0, 1'b0, 1'b1, 3'h7);
        conv(3'h7);
        prd(16'ha000);
        prd(16'hb000);
        pwr(16'h8606);
        chk(o_register_mode, 1);
        pwr(16'h0603);
        prd(16'h0606);
        pwr(16'h8000);
        chk(o_register_mode, 0);
        conv(3'h0);
        prd(16'ha006);
        prd(16'hb006);
        $display("test sw_parallel done");
        // Software mode, two-line serial
        boot(2'h0, 1'b1, 1'b1, 3'h0);
        conv(3'h0);
        sfr(16'h8000, qa, qb);
        chk(qa, 16'ha000);
        chk(qb, 16'hb000);
        sfr(16'h0600, qa, qb);
        sfr(16'h8605, qa, qb);
        chk(qa, 16'h0600);
        sfr(16'h8000, qa, qb);
        chk(qa, 16'h0605);
        conv(3'h0);
        sfr(16'h8000, qa, qb);
        chk(qa, 16'ha005);
        chk(qb, 16'hb005);
        $display("test sw_serial_two done");
        // One-line serial; strap flipped after release must not count
        boot(2'h0, 1'b1, 1'b0, 3'h0);
        i_one_wire_select <= 1;
        conv(3'h0);
        sfr(16'h8000, qa, qb);
        chk(qa, 16'ha000);
        sfr(16'h8000, qa, qb);
        chk(qa, 16'hb000);
        $display("test sw_serial_one done");
        results;
    end
    // Watchdog, well past the expected run length
    initial begin
        step(40000);
        bad_count++;
        $display("mismatch at %0t: run hung", $time);
        results;
    end
endmodule
